// File: src/bus_cycle_sample_qualifier.sv
// What this block does
// - One master sample leaves per bus cycle, whatever its length.
// - Groups are caught when each is valid, then sent to trigger and store.
// - Strobe, address and data run through a two-clock delay first.
// - Last-transfer and data-valid qualifiers are combinational decodes of the delayed bus and state.
// - Clock and qualifiers only time the capture and are not stored.
// - Cache-controller ready counts as a ready strobe; idle reads inactive.
// - Cache-controller address strobe is ignored.
// - Backoff, memory-or-io and reset steer every capture; hold-ack steers it only with alternate masters excluded.
// - First sample as soon as one clock after strobe, burst ones one after ready.
// - A pipelined cycle can sample as soon as two clocks after the prior last ready.
// - With alternate masters excluded, no new strobe starts a cycle while hold-ack is high.
// - Backoff aborts the cycle in progress; the restart is caught anew.
`timescale 1ns/1ns
`include "bcsq_consts.svh"
module bus_cycle_sample_qualifier
  import bcsq_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic addr_strobe_n_in,
  input wire logic xfer_ready_n_in,
  input wire logic cachectl_xfer_ready_n_in,
  input wire logic cachectl_addr_strobe_n_in,
  input wire logic hold_ack_in,
  input wire logic backoff_n_in,
  input wire logic mem_io_in,
  input wire logic cpu_reset_in,
  input wire logic write_in,
  input wire logic data_code_in,
  input wire logic lock_n_in,
  input wire logic cacheable_n_in,
  input wire logic cache_en_n_in,
  input wire logic [`BE_W-1:0] byte_en_n_in,
  input wire logic [`ADDR_W-1:0] addr_in,
  input wire logic [`DATA_W-1:0] data_in,
  input wire logic exclude_alt_master_in,
  output logic trig_valid_out,
  output bcsq_pkg::sample_t trig_sample_out,
  output bcsq_pkg::sample_t sample_out,
  output logic sample_valid_out,
  input wire logic sample_ready_in,
  output logic missed_cycle_out
);
  import bcsq_pkg::*;

  localparam int PW = 12 + `BE_W + `ADDR_W + `DATA_W;
  localparam int DW = 4 + `CTRL_W + `BE_W + `ADDR_W + `DATA_W;

  function automatic logic ready_seen(input logic rdy_n, input logic rdyc_n);
    ready_seen = !rdy_n || !rdyc_n;
  endfunction : ready_seen

  // Cache-controller strobe is deliberately left out of the pin bundle
  wire [PW-1:0] pin_raw = {!addr_strobe_n_in, xfer_ready_n_in,
    cachectl_xfer_ready_n_in, hold_ack_in, backoff_n_in, mem_io_in,
    cpu_reset_in, write_in, data_code_in, lock_n_in, cacheable_n_in,
    cache_en_n_in, byte_en_n_in, addr_in, data_in};
  logic [PW-1:0] meta_ff;
  logic [PW-1:0] pin_ff;

  wire s_ads = pin_ff[PW-1];
  wire s_rdy = ready_seen(pin_ff[PW-2], pin_ff[PW-3]);
  wire s_hold = pin_ff[PW-4];
  wire s_backoff_n_n = pin_ff[PW-5];
  wire s_memio = pin_ff[PW-6];
  wire s_cpurst = pin_ff[PW-7];
  wire s_cache_n = pin_ff[PW-11];
  wire s_ken_n = pin_ff[PW-12];
  wire [`CTRL_W-1:0] s_ctrl = {pin_ff[PW-8], pin_ff[PW-9],
    pin_ff[PW-10], s_memio, s_backoff_n_n, s_hold};
  wire [`BE_W+`ADDR_W+`DATA_W-1:0] s_bus =
    pin_ff[`BE_W+`ADDR_W+`DATA_W-1:0];
  wire s_burst = s_memio && !s_cache_n && !s_ken_n;

  // Controls ride with the ready that validated them
  wire [DW-1:0] dly_in = {s_ads, s_rdy, s_burst, s_cpurst, s_ctrl, s_bus};
  logic [DW-1:0] dly_ff [`BUS_DELAY];

  wire [DW-1:0] d_vec = dly_ff[`BUS_DELAY-1];
  wire d_ads = d_vec[DW-1];
  wire d_rdy = d_vec[DW-2];
  wire d_burst = d_vec[DW-3];
  wire d_cpurst = d_vec[DW-4];
  wire [`CTRL_W-1:0] d_ctrl = d_vec[DW-5 -: `CTRL_W];
  wire d_hold = d_ctrl[0];
  wire d_backoff_n_n = d_ctrl[1];
  wire [`BE_W-1:0] d_be = d_vec[`ADDR_W+`DATA_W +: `BE_W];
  wire [`ADDR_W-1:0] d_addr = d_vec[`DATA_W +: `ADDR_W];
  wire [`DATA_W-1:0] d_data = d_vec[`DATA_W-1:0];

  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [1:0] beat_ff;
  logic pend_ff;
  logic [`ADDR_W-1:0] pend_addr_ff;
  logic [`ADDR_W-1:0] cur_addr_ff;
  sample_t sample_ff;
  logic trig_ff;
  logic miss_ff;
  logic [1:0] excl_ff;

  wire excl = excl_ff[1];
  wire start = d_ads && !(excl && d_hold);
  // Delayed with the bus so the abort meets the beat it cancels
  wire abort = !d_backoff_n_n || d_cpurst;
  wire data_valid_q = (state_ff == ST_XFER) && d_rdy && !abort;
  wire last_q = data_valid_q &&
    (!d_burst || beat_ff == `LAST_BEAT);
  wire busy = (state_ff != ST_IDLE);
  wire pipe_q = start && (busy || pend_ff);
  wire fifo_ready;
  wire fifo_push = (state_ff == ST_EMIT);
  wire emit_done = fifo_push && fifo_ready;
  // A strobe parked as EMIT closes is picked up again from IDLE
  wire take_pend = pend_ff && !abort &&
    (emit_done || state_ff == ST_IDLE);
  wire [`ADDR_W-1:0] first_addr = pend_ff ? pend_addr_ff : d_addr;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
        if ((start || pend_ff) && !abort)
        begin
          nxt_state = ST_XFER;
        end
      ST_XFER:
        if (abort)
        begin
          nxt_state = ST_IDLE;
        end
        else if (last_q)
        begin
          nxt_state = ST_EMIT;
        end
      ST_EMIT:
        if (emit_done)
        begin
          nxt_state = take_pend ? ST_XFER : ST_IDLE;
        end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    meta_ff <= pin_raw;
    pin_ff <= meta_ff;
    excl_ff <= {excl_ff[0], exclude_alt_master_in};
    dly_ff[0] <= dly_in;
  end

  genvar g;
  generate
    for (g = 1; g < `BUS_DELAY; g++)
    begin : g_dly
      always_ff @(posedge sys_clk_in)
      begin
        dly_ff[g] <= dly_ff[g-1];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      state_ff <= ST_IDLE;
      beat_ff <= 2'h0;
      pend_ff <= 1'b0;
      pend_addr_ff <= '0;
      cur_addr_ff <= '0;
      sample_ff <= '0;
      trig_ff <= 1'b0;
      miss_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      trig_ff <= emit_done;
      miss_ff <= pipe_q && pend_ff && !take_pend;
      if (take_pend || (state_ff == ST_IDLE && start))
      begin
        cur_addr_ff <= first_addr;
        beat_ff <= 2'h0;
      end
      else if (data_valid_q)
      begin
        beat_ff <= beat_ff + 2'h1;
      end
      if (abort)
      begin
        pend_ff <= 1'b0;
      end
      else if (pipe_q && (!pend_ff || take_pend))
      begin
        pend_ff <= 1'b1;
        pend_addr_ff <= d_addr;
      end
      else if (take_pend)
      begin
        pend_ff <= 1'b0;
      end
      // Qualifiers and clock never enter the stored word
      if (last_q)
      begin
        sample_ff <= {cur_addr_ff, d_data, d_be, d_ctrl};
      end
    end
  end

  sample_fifo #(
    .WIDTH(`SAMPLE_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .wr_data_in(sample_ff),
    .wr_valid_in(fifo_push),
    .wr_ready_out(fifo_ready),
    .rd_data_out(sample_out),
    .rd_valid_out(sample_valid_out),
    .rd_ready_in(sample_ready_in)
  );

  assign trig_valid_out = trig_ff;
  assign trig_sample_out = sample_ff;
  assign missed_cycle_out = miss_ff;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_push_emit;
    fifo_push |-> $past(last_q) || $past(fifo_push);
  endproperty
  a_push_emit: assert property (p_push_emit)
    else $error("push without a finished cycle");

  property p_last_emit;
    last_q && !abort |=> state_ff == ST_EMIT ##0 fifo_push;
  endproperty
  a_last_emit: assert property (p_last_emit)
    else $error("last transfer did not emit");

  property p_ads_delay;
    s_ads |-> ##2 d_ads;
  endproperty
  a_ads_delay: assert property (p_ads_delay)
    else $error("strobe delay is not two clocks");

  property p_data_delay;
    s_rdy ##2 1'b1 |-> d_data == $past(s_bus[`DATA_W-1:0], 2) && d_rdy;
  endproperty
  a_data_delay: assert property (p_data_delay)
    else $error("data delay is not two clocks");

  property p_dv_cause;
    data_valid_q |-> $past(s_rdy, 2) && state_ff == ST_XFER;
  endproperty
  a_dv_cause: assert property (p_dv_cause)
    else $error("data valid without delayed ready");

  property p_excl;
    excl && d_hold && !pend_ff && state_ff == ST_IDLE
      |=> state_ff == ST_IDLE;
  endproperty
  a_excl: assert property (p_excl)
    else $error("cycle started under hold-ack");

  property p_abort;
    !d_backoff_n_n && state_ff == ST_XFER |=> state_ff == ST_IDLE && !pend_ff;
  endproperty
  a_abort: assert property (p_abort)
    else $error("backoff did not abort");

  property p_cpurst;
    d_cpurst |=> !pend_ff && state_ff != ST_XFER;
  endproperty
  a_cpurst: assert property (p_cpurst)
    else $error("reset left cycle tracking");

  property p_sample_addr;
    last_q |=> sample_ff[`SAMPLE_W-1 -: `ADDR_W] == $past(cur_addr_ff);
  endproperty
  a_sample_addr: assert property (p_sample_addr)
    else $error("sample address mismatch");

  c_burst: cover property (last_q && d_burst);
  c_pipe: cover property (take_pend);
  c_abort: cover property (abort && state_ff == ST_XFER);
  c_full: cover property (fifo_push && !fifo_ready);
endmodule : bus_cycle_sample_qualifier

// File: src/bcsq_consts.svh
`ifndef BCSQ_CONSTS_SVH
`define BCSQ_CONSTS_SVH
`define ADDR_W 32
`define DATA_W 64
`define BE_W 8
`define CTRL_W 6
`define SAMPLE_W 110
`define BUS_DELAY 2
`define LAST_BEAT 2'h3
`define FIFO_DEPTH 8
`endif

// File: src/bcsq_pkg.sv
package bcsq_pkg;
`include "bcsq_consts.svh"
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_EMIT = 2'b10
  } seq_state_t;
  typedef logic [`SAMPLE_W-1:0] sample_t;
endpackage : bcsq_pkg

// File: src/sample_fifo.sv
`timescale 1ns/1ns
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wptr_ff;
  logic [AW:0] rptr_ff;
  wire full = (wptr_ff[AW] != rptr_ff[AW]) &&
              (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
  wire empty = (wptr_ff == rptr_ff);
  wire push = wr_valid_in && !full;
  wire pop = rd_ready_in && !empty;

  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem_ff[rptr_ff[AW-1:0]];

  always_ff @(posedge sys_clk_in)
  begin
    if (push)
    begin
      mem_ff[wptr_ff[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end
    else
    begin
      wptr_ff <= wptr_ff + (AW+1)'(push);
      rptr_ff <= rptr_ff + (AW+1)'(pop);
    end
  end
endmodule : sample_fifo

// File: dv/bus_host_model.sv
`timescale 1ns/1ns
module bus_host_model (
  input wire logic sys_clk_in,
  output logic as_n_out,
  output logic rdy_n_out,
  output logic crdy_n_out,
  output logic cas_n_out,
  output logic hold_out,
  output logic backoff_n_n_out,
  output logic crst_out,
  output logic cab_n_out,
  output logic [7:0] be_n_out,
  output logic [31:0] addr_out,
  output logic [63:0] data_out
);
  initial
  begin
    {as_n_out, rdy_n_out, crdy_n_out, cas_n_out} = 4'hE;
    {hold_out, backoff_n_n_out, crst_out, cab_n_out} = 4'h5;
    {be_n_out, addr_out, data_out} = '0;
  end

  // Kind 1 backs off and kind 2 resets the core in place of the last ready
  task automatic cycle(input logic [31:0] a, input logic [63:0] d,
    input int beats, kind, input logic h);
    logic last;
    logic ok;
    @(posedge sys_clk_in);
    {as_n_out, cas_n_out, hold_out} <= {2'h1, h};
    {addr_out, be_n_out, cab_n_out} <= {a, a[7:0], beats != 4};
    for (int i = 1; i <= beats; i++)
    begin
      last = (i == beats);
      ok = !last || kind == 0;
      @(posedge sys_clk_in);
      as_n_out <= 1'h1;
      data_out <= last ? d : ~d;
      rdy_n_out <= !(ok && i != 2);
      crdy_n_out <= !(ok && i == 2);
      backoff_n_n_out <= !(last && kind == 1);
      crst_out <= last && kind == 2;
    end
    @(posedge sys_clk_in);
    // Released lines show inverted garbage, not the old value
    {rdy_n_out, crdy_n_out, backoff_n_n_out, crst_out} <= 4'hE;
    {hold_out, addr_out, data_out} <= {1'h0, ~a, ~d};
    // Idle while the strobe is high: must not start a cycle
    cas_n_out <= 1'h0;
  endtask : cycle

  // A pipelined strobe follows the first; an optional third is refused
  task automatic pipe(input logic [31:0] a, input logic [63:0] d,
    input logic third);
    @(posedge sys_clk_in);
    {as_n_out, hold_out, cab_n_out} <= 3'h1;
    {addr_out, be_n_out} <= {a, a[7:0]};
    @(posedge sys_clk_in);
    addr_out <= a + 32'h8;
    @(posedge sys_clk_in);
    as_n_out <= !third;
    addr_out <= a + 32'h10;
    @(posedge sys_clk_in);
    as_n_out <= 1'h1;
    {rdy_n_out, data_out} <= {1'h0, d};
    @(posedge sys_clk_in);
    rdy_n_out <= 1'h1;
    @(posedge sys_clk_in);
    {rdy_n_out, data_out} <= {1'h0, ~d};
    @(posedge sys_clk_in);
    {rdy_n_out, addr_out, data_out} <= {1'h1, ~a, d};
  endtask : pipe
endmodule : bus_host_model

// File: dv/bus_cycle_sample_qualifier_tb_top.sv
`timescale 1ns/1ns
`include "bcsq_consts.svh"
module bus_cycle_sample_qualifier_tb_top;
  import bcsq_pkg::*;
  logic sys_clk_in = 1'h0;
  logic rstn_in = 1'h0;
  logic exclude_alt_master_in = 1'h0;
  logic sample_ready_in = 1'h1;
  logic mem_io = 1'h1;
  int n_miss = 0;
  logic as_n, rdy_n, crdy_n, cas_n, hold, backoff_n_n, crst, cab_n;
  logic [7:0] be_n;
  logic [31:0] addr;
  logic [63:0] data;
  logic trig_valid_out, sample_valid_out, missed_cycle_out;
  sample_t trig_sample_out, sample_out;
  sample_t got[$];
  int err_count = 0;
  int n_tests = 0;
  int pops = 0;
  int cyc = 0;
  int t_rdy = 0;
  int t_trig = 0;

  always #4 sys_clk_in = ~sys_clk_in;

  bus_host_model i_host (.sys_clk_in, .as_n_out(as_n), .rdy_n_out(rdy_n),
    .crdy_n_out(crdy_n), .cas_n_out(cas_n), .hold_out(hold),
    .backoff_n_n_out(backoff_n_n), .crst_out(crst), .cab_n_out(cab_n),
    .be_n_out(be_n), .addr_out(addr), .data_out(data));

  bus_cycle_sample_qualifier i_dut (.sys_clk_in, .rstn_in,
    .addr_strobe_n_in(as_n), .xfer_ready_n_in(rdy_n),
    .cachectl_xfer_ready_n_in(crdy_n), .cachectl_addr_strobe_n_in(cas_n),
    .hold_ack_in(hold), .backoff_n_in(backoff_n_n), .mem_io_in(mem_io),
    .cpu_reset_in(crst), .write_in(1'h1), .data_code_in(1'h1),
    .lock_n_in(1'h1), .cacheable_n_in(cab_n), .cache_en_n_in(1'h0),
    .byte_en_n_in(be_n), .addr_in(addr), .data_in(data),
    .exclude_alt_master_in, .trig_valid_out, .trig_sample_out,
    .sample_out, .sample_valid_out, .sample_ready_in, .missed_cycle_out);

  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (rdy_n === 1'h0) t_rdy <= cyc;
    if (trig_valid_out === 1'h1) got.push_back(trig_sample_out);
    if (trig_valid_out === 1'h1) t_trig <= cyc;
    if (missed_cycle_out === 1'h1) n_miss <= n_miss + 1;
    if (sample_valid_out === 1'h1 && sample_ready_in) pops <= pops + 1;
  end

  task automatic check(input string what, input logic [109:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic xfer(input logic [31:0] a, input logic [63:0] d,
    input int beats, kind, input logic h, input int n);
    got.delete();
    i_host.cycle(a, d, beats, kind, h);
    repeat (16) @(posedge sys_clk_in);
    check("sample count", got.size(), n);
    if (n == 1)
    begin
      check("sample word", got[0], {a, d, a[7:0], 5'h1F, h});
      check("ready to sample", t_trig - t_rdy, 6);
    end
  endtask : xfer

  task automatic t_plain;
    xfer(32'h1000_0104, 64'h0123_4567_89AB_CDEF, 1, 0, 1'h0, 1);
    xfer(32'h1000_0208, 64'hFEDC_BA98_7654_3210, 4, 0, 1'h0, 1);
    $display("single and burst done");
  endtask : t_plain

  task automatic t_abort;
    xfer(32'h2000_0010, 64'h5555_0000_AAAA_FFFF, 1, 1, 1'h0, 0);
    xfer(32'h2000_0010, 64'h5555_0000_AAAA_FFFF, 1, 0, 1'h0, 1);
    xfer(32'h2000_0420, 64'h0F0F_0F0F_0F0F_0F0F, 4, 2, 1'h0, 0);
    xfer(32'h2000_0440, 64'hF0F0_F0F0_F0F0_F0F0, 1, 0, 1'h0, 1);
    $display("backoff and core reset done");
  endtask : t_abort

  task automatic t_hold;
    exclude_alt_master_in <= 1'h1;
    xfer(32'h4000_0080, 64'h0000_1111_2222_3333, 1, 0, 1'h1, 0);
    xfer(32'h4000_0090, 64'h4444_5555_6666_7777, 1, 0, 1'h0, 1);
    exclude_alt_master_in <= 1'h0;
    xfer(32'h4000_00A0, 64'h8888_9999_AAAA_BBBB, 1, 0, 1'h1, 1);
    $display("hold acknowledge done");
  endtask : t_hold

  // An io cycle never bursts, so its first ready closes it
  task automatic t_io;
    logic [63:0] d;
    d = 64'h0000_0000_1234_5678;
    mem_io <= 1'h0;
    got.delete();
    i_host.cycle(32'h5000_0000, d, 4, 0, 1'h0);
    repeat (16) @(posedge sys_clk_in);
    mem_io <= 1'h1;
    check("io count", got.size(), 1);
    check("io word", got[0], {32'h5000_0000, ~d, 8'h00, 6'h3A});
    $display("io cycle done");
  endtask : t_io

  task automatic t_pipe;
    logic [31:0] a;
    logic [63:0] d;
    int m0;
    a = 32'h6000_0100;
    d = 64'hA5A5_0000_5A5A_FFFF;
    for (int k = 0; k < 2; k++)
    begin
      m0 = n_miss;
      got.delete();
      i_host.pipe(a, d, k[0]);
      repeat (16) @(posedge sys_clk_in);
      check("pipe count", got.size(), 2);
      check("pipe first", got[0], {a, d, a[7:0], 6'h3E});
      check("pipe second", got[1], {a + 32'h8, ~d, a[7:0], 6'h3E});
      check("missed", n_miss - m0, k);
    end
    $display("pipelined cycles done");
  endtask : t_pipe

  task automatic t_fifo;
    int p0;
    sample_ready_in <= 1'h0;
    got.delete();
    for (int i = 0; i <= `FIFO_DEPTH; i++)
      i_host.cycle(32'h3000_0000 + i, 64'h0, 1, 0, 1'h0);
    repeat (16) @(posedge sys_clk_in);
    check("pushes while full", got.size(), `FIFO_DEPTH);
    check("head held", sample_valid_out, 1'h1);
    check("head word", sample_out[109:78], 32'h3000_0000);
    p0 = pops;
    sample_ready_in <= 1'h1;
    repeat (24) @(posedge sys_clk_in);
    check("drained", pops - p0, `FIFO_DEPTH + 1);
    check("empty", sample_valid_out, 1'h0);
    check("last out", got[`FIFO_DEPTH][109:78], 32'h3000_0008);
    $display("buffer fill and drain done");
  endtask : t_fifo

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    rstn_in <= 1'h1;
    repeat (4) @(posedge sys_clk_in);
    t_plain;
    t_abort;
    t_hold;
    t_io;
    t_pipe;
    t_fifo;
    test_done;
  end

  // Whole sequence needs well under a thousand clocks
  initial
  begin
    repeat (3000) @(posedge sys_clk_in);
    err_count++;
    test_done;
  end
endmodule : bus_cycle_sample_qualifier_tb_top
